// ===== include/psd_pkg.sv
// Shared constants, register map and carrier types of the presence gate decision block.
package psd_pkg;
  localparam int NUM_GATES = 8;
  localparam int EW = 7;
  localparam logic [6:0] ENERGY_MAX = 7'h64;
  localparam int GATE_LEN_MM = 750;
  localparam logic [3:0] LIMIT_MIN = 4'h1;
  localparam logic [3:0] LIMIT_MAX = 4'h8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEC_NS = 1000000000;
  localparam int TICKS_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam int CLK_HZ = SEC_NS / CLK_PERIOD_NS;
  localparam int BAUD_RATE = 256000;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam logic [7:0] REPORT_HDR = 8'hA5;
  localparam logic [4:0] REP_LAST_BASIC = 5'h01;
  localparam logic [4:0] REP_LAST_ENG = 5'h11;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_LIMITS = 8'h10;
  localparam logic [7:0] ADDR_HOLD = 8'h14;
  localparam logic [2:0] PAGE_THR = 3'h1;
  localparam logic [2:0] PAGE_ENERGY = 3'h2;
  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ENG = 1;
  localparam int CTRL_SAVE = 2;
  localparam int ST_CHANGE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_SENT = 2;
  localparam int STATUS_W = 3;
  localparam int LIM_STA_LSB = 8;
  localparam int THR_STA_LSB = 8;
  // Reset values.
  localparam logic [3:0] RST_LIMIT = 4'h8;
  localparam logic [15:0] RST_HOLD = 16'h0005;
  localparam logic [NUM_GATES*EW-1:0] RST_MOT_THR =
    {7'h0F, 7'h0F, 7'h0F, 7'h0F, 7'h14, 7'h1E, 7'h28, 7'h32};
  localparam logic [NUM_GATES*EW-1:0] RST_STA_THR =
    {7'h14, 7'h14, 7'h1E, 7'h1E, 7'h28, 7'h28, 7'h00, 7'h00};

  typedef enum logic [1:0] {
    PSD_NONE = 2'b00,
    PSD_MOVING = 2'b01,
    PSD_STATIC = 2'b10
  } psd_state_t;

  typedef struct packed {
    logic [EW-1:0] motion;
    logic [EW-1:0] still;
  } psd_energy_t;

  typedef struct packed {
    logic [3:0] motLimit;
    logic [3:0] staLimit;
    logic [15:0] holdSecs;
    logic [NUM_GATES-1:0][EW-1:0] motThr;
    logic [NUM_GATES-1:0][EW-1:0] staThr;
  } psd_cfg_t;
endpackage

// ===== hw/psd_hold_timer.sv
// No-one hold timer that stretches presence by a number of seconds.
`timescale 1ns/1ps
`default_nettype none
module psd_hold_timer #(
  parameter int TICKS_PER_SEC = psd_pkg::TICKS_PER_SEC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic detect,
  input wire logic [15:0] holdSecs,
  output logic occupied
);
  logic occ_r, occ_nxt;
  logic [15:0] sec_r, sec_nxt;
  logic [31:0] pre_r, pre_nxt;

  always_comb begin
    occ_nxt = occ_r;
    sec_nxt = sec_r;
    pre_nxt = pre_r;
    if (detect) begin
      occ_nxt = 1'b1;
      sec_nxt = 16'h0000;
      pre_nxt = 32'h0000_0000;
    end else if (occ_r) begin
      if (sec_r >= holdSecs) begin
        occ_nxt = 1'b0;
      end else if (pre_r == 32'(TICKS_PER_SEC - 1)) begin
        pre_nxt = 32'h0000_0000;
        sec_nxt = sec_r + 16'h0001;
      end else begin
        pre_nxt = pre_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      occ_r <= 1'b0;
      sec_r <= 16'h0000;
      pre_r <= 32'h0000_0000;
    end else begin
      occ_r <= occ_nxt;
      sec_r <= sec_nxt;
      pre_r <= pre_nxt;
    end
  end

  assign occupied = occ_r;

  property p_hold_clear_only_idle;
    @(posedge clock) disable iff (!rst_n) $fell(occ_r) |-> !$past(detect) && $past(sec_r) >= $past(holdSecs);
  endproperty
  a_hold_clear_only_idle: assert property (p_hold_clear_only_idle) else $error("Presence dropped early.");

  property p_detect_sets;
    @(posedge clock) disable iff (!rst_n) detect |=> occ_r && sec_r == 16'h0000;
  endproperty
  a_detect_sets: assert property (p_detect_sets) else $error("Detection did not restart hold.");
endmodule
`default_nettype wire

// ===== hw/psd_uart_tx.sv
// Serial transmitter, 8 data bits, no parity, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module psd_uart_tx #(
  parameter int BAUD_DIV = psd_pkg::BAUD_DIV
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic txd
);
  typedef enum logic {PSD_TX_IDLE = 1'b0, PSD_TX_SEND = 1'b1} psd_tx_t;
  psd_tx_t st_r, st_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [15:0] div_r, div_nxt;

  // bit timing at the link rate
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    div_nxt = div_r;
    case (st_r)
      PSD_TX_IDLE: begin
        if (txValid) begin
          st_nxt = PSD_TX_SEND;
          sh_nxt = {1'b1, txData, 1'b0};
          bit_nxt = 4'h0;
          div_nxt = 16'h0000;
        end
      end
      PSD_TX_SEND: begin
        if (div_r == 16'(BAUD_DIV - 1)) begin
          div_nxt = 16'h0000;
          sh_nxt = {1'b1, sh_r[9:1]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h9) begin
            st_nxt = PSD_TX_IDLE;
          end
        end else begin
          div_nxt = div_r + 16'h0001;
        end
      end
      default: st_nxt = PSD_TX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= PSD_TX_IDLE;
      sh_r <= 10'h3FF;
      bit_r <= 4'h0;
      div_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
    end
  end

  assign txReady = (st_r == PSD_TX_IDLE);
  // The shifter refills with ones, so its low bit is the idle level between bytes.
  assign txd = sh_r[0];

  property p_start_bit;
    @(posedge clock) disable iff (!rst_n) txValid && txReady |=> !txd [*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("Start bit not held low.");
endmodule
`default_nettype wire

// ===== hw/psd_gate_decision.sv
// Presence decision over range gates with AHB-Lite registers and serial reporting.
//
// How it works
// - Gates are fixed 0.75 m slices from zero.
// - Separate motion and static farthest gates, 1..8.
// - Present only when energy exceeds gate threshold.
// - Per-gate thresholds 0..100; 100 disables gate.
// - Hold presence for set seconds, restart on detection.
// - Hold time accepts 0 to 65535 seconds.
// - Settings saved to and restored from nonvolatile store.
// - Serial link runs at 256000 baud.
// - Settings access refused while reporting runs.
// - Engineering mode reports every gate's energies.
// - State is moving, stationary or nobody.
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module psd_gate_decision #(
  parameter int TICKS_PER_SEC = psd_pkg::TICKS_PER_SEC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frameValid,
  input wire psd_pkg::psd_energy_t [psd_pkg::NUM_GATES-1:0] gateEnergy,
  input wire logic nvmCfgValid,
  input wire psd_pkg::psd_cfg_t nvmCfgIn,
  output logic nvmSaveStb,
  output psd_pkg::psd_cfg_t nvmCfgOut,
  output logic txd,
  output psd_pkg::psd_state_t targetState,
  output logic irq
);
  localparam int NG = psd_pkg::NUM_GATES;
  localparam int STATUS_W_L = psd_pkg::STATUS_W;

  // ************************************************************
  // Register bus
  // ************************************************************
  logic dpValid_r, dpValid_nxt;
  logic dpWrite_r, dpWrite_nxt;
  logic [7:0] dpAddr_r, dpAddr_nxt;
  logic run_r, run_nxt;
  logic eng_r, eng_nxt;
  logic save_r, save_nxt;
  logic [STATUS_W_L-1:0] status_r, status_nxt;
  logic [STATUS_W_L-1:0] mask_r, mask_nxt;
  psd_pkg::psd_cfg_t cfg_r, cfg_nxt;
  logic refused;
  logic [STATUS_W_L-1:0] events;
  logic [2:0] wGate;
  logic [6:0] wMot, wSta;

  function automatic logic isCfgAddr(input logic [7:0] a);
    isCfgAddr = (a == psd_pkg::ADDR_LIMITS) || (a == psd_pkg::ADDR_HOLD) ||
      (a[7:5] == psd_pkg::PAGE_THR);
  endfunction

  function automatic logic [6:0] clampEnergy(input logic [6:0] v);
    clampEnergy = (v > psd_pkg::ENERGY_MAX) ? psd_pkg::ENERGY_MAX : v;
  endfunction

  assign dpValid_nxt = hsel && hready && htrans[1];
  assign dpWrite_nxt = hwrite;
  assign dpAddr_nxt = dpValid_nxt ? haddr[7:0] : dpAddr_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wGate = dpAddr_r[4:2];
  assign wMot = clampEnergy(hwdata[6:0]);
  assign wSta = clampEnergy(hwdata[psd_pkg::THR_STA_LSB +: 7]);

  assign refused = dpValid_r && isCfgAddr(dpAddr_r) && run_r;

  always_comb begin
    run_nxt = run_r;
    eng_nxt = eng_r;
    save_nxt = 1'b0;
    mask_nxt = mask_r;
    cfg_nxt = cfg_r;
    status_nxt = status_r;
    if (nvmCfgValid && !run_r) begin
      cfg_nxt = nvmCfgIn;
    end
    if (dpValid_r && dpWrite_r) begin
      case (dpAddr_r)
        psd_pkg::ADDR_CTRL: begin
          run_nxt = hwdata[psd_pkg::CTRL_RUN];
          eng_nxt = hwdata[psd_pkg::CTRL_ENG];
          save_nxt = hwdata[psd_pkg::CTRL_SAVE] && !run_r;
        end
        psd_pkg::ADDR_STATUS: status_nxt = status_r & ~hwdata[STATUS_W_L-1:0];
        psd_pkg::ADDR_MASK: mask_nxt = hwdata[STATUS_W_L-1:0];
        psd_pkg::ADDR_LIMITS: begin
          if (!run_r && hwdata[3:0] >= psd_pkg::LIMIT_MIN && hwdata[3:0] <= psd_pkg::LIMIT_MAX) begin
            cfg_nxt.motLimit = hwdata[3:0];
          end
          if (!run_r && hwdata[psd_pkg::LIM_STA_LSB +: 4] >= psd_pkg::LIMIT_MIN &&
              hwdata[psd_pkg::LIM_STA_LSB +: 4] <= psd_pkg::LIMIT_MAX) begin
            cfg_nxt.staLimit = hwdata[psd_pkg::LIM_STA_LSB +: 4];
          end
        end
        psd_pkg::ADDR_HOLD: begin
          if (!run_r) begin
            cfg_nxt.holdSecs = hwdata[15:0];
          end
        end
        default: begin
          if (!run_r && dpAddr_r[7:5] == psd_pkg::PAGE_THR) begin
            cfg_nxt.motThr[wGate] = wMot;
            cfg_nxt.staThr[wGate] = wSta;
          end
        end
      endcase
    end
    // Events set after the clear so a same-cycle event is kept.
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpAddr_r <= 8'h00;
      run_r <= 1'b0;
      eng_r <= 1'b0;
      save_r <= 1'b0;
      status_r <= '0;
      mask_r <= '0;
      cfg_r <= '{motLimit: psd_pkg::RST_LIMIT, staLimit: psd_pkg::RST_LIMIT,
                 holdSecs: psd_pkg::RST_HOLD, motThr: psd_pkg::RST_MOT_THR,
                 staThr: psd_pkg::RST_STA_THR};
    end else begin
      dpValid_r <= dpValid_nxt;
      dpWrite_r <= dpWrite_nxt;
      dpAddr_r <= dpAddr_nxt;
      run_r <= run_nxt;
      eng_r <= eng_nxt;
      save_r <= save_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign nvmSaveStb = save_r;
  assign nvmCfgOut = cfg_r;
  assign irq = |(status_r & mask_r);

  // ************************************************************
  // Gate decision
  // ************************************************************
  psd_pkg::psd_energy_t [NG-1:0] energy_r, energy_nxt;
  logic [NG-1:0] motAbove, staAbove;
  logic motHit_r, motHit_nxt;
  logic staHit_r, staHit_nxt;
  psd_pkg::psd_state_t pres_r, pres_nxt;
  psd_pkg::psd_state_t state_r, state_nxt;
  logic occupied;

  // gate g spans g*0.75 m onward
  for (genvar g = 0; g < NG; g++) begin : g_gate
    assign motAbove[g] = (4'(g) < cfg_r.motLimit) && (gateEnergy[g].motion > cfg_r.motThr[g]);
    assign staAbove[g] = (4'(g) < cfg_r.staLimit) && (gateEnergy[g].still > cfg_r.staThr[g]);
  end

  assign energy_nxt = frameValid ? gateEnergy : energy_r;
  assign motHit_nxt = frameValid ? |motAbove : motHit_r;
  assign staHit_nxt = frameValid ? |staAbove : staHit_r;

  psd_hold_timer #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_hold (
    .clock(clock),
    .rst_n(rst_n),
    .detect(motHit_r || staHit_r),
    .holdSecs(cfg_r.holdSecs),
    .occupied(occupied)
  );

  always_comb begin
    pres_nxt = pres_r;
    if (motHit_r) begin
      pres_nxt = psd_pkg::PSD_MOVING;
    end else if (staHit_r) begin
      pres_nxt = psd_pkg::PSD_STATIC;
    end
    state_nxt = occupied ? pres_nxt : psd_pkg::PSD_NONE;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      energy_r <= '0;
      motHit_r <= 1'b0;
      staHit_r <= 1'b0;
      pres_r <= psd_pkg::PSD_NONE;
      state_r <= psd_pkg::PSD_NONE;
    end else begin
      energy_r <= energy_nxt;
      motHit_r <= motHit_nxt;
      staHit_r <= staHit_nxt;
      pres_r <= pres_nxt;
      state_r <= state_nxt;
    end
  end

  assign targetState = state_r;

  // ************************************************************
  // Serial reporting
  // ************************************************************
  logic repBusy_r, repBusy_nxt;
  logic [4:0] repIdx_r, repIdx_nxt;
  logic repEng_r, repEng_nxt;
  logic txReady;
  logic [7:0] txByte;
  logic repSent;

  function automatic logic [7:0] reportByte(input logic [4:0] idx,
      input psd_pkg::psd_state_t st, input psd_pkg::psd_energy_t [NG-1:0] e);
    logic [3:0] g;
    g = idx[4:1] - 4'h1;
    if (idx == 5'h00) begin
      reportByte = psd_pkg::REPORT_HDR;
    end else if (idx == 5'h01) begin
      reportByte = {6'h00, st};
    end else if (!idx[0]) begin
      reportByte = {1'b0, e[g[2:0]].motion};
    end else begin
      reportByte = {1'b0, e[g[2:0]].still};
    end
  endfunction

  assign txByte = reportByte(repIdx_r, state_r, energy_r);

  always_comb begin
    repBusy_nxt = repBusy_r;
    repIdx_nxt = repIdx_r;
    repEng_nxt = repEng_r;
    repSent = 1'b0;
    if (!repBusy_r) begin
      if (frameValid && run_r) begin
        repBusy_nxt = 1'b1;
        repIdx_nxt = 5'h00;
        repEng_nxt = eng_r;
      end
    end else if (txReady) begin
      repIdx_nxt = repIdx_r + 5'h01;
      if (repIdx_r == (repEng_r ? psd_pkg::REP_LAST_ENG : psd_pkg::REP_LAST_BASIC)) begin
        repBusy_nxt = 1'b0;
        repSent = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      repBusy_r <= 1'b0;
      repIdx_r <= 5'h00;
      repEng_r <= 1'b0;
    end else begin
      repBusy_r <= repBusy_nxt;
      repIdx_r <= repIdx_nxt;
      repEng_r <= repEng_nxt;
    end
  end

  psd_uart_tx #(
    .BAUD_DIV(psd_pkg::BAUD_DIV)
  ) u_tx (
    .clock(clock),
    .rst_n(rst_n),
    .txValid(repBusy_r),
    .txData(txByte),
    .txReady(txReady),
    .txd(txd)
  );

  assign events[psd_pkg::ST_CHANGE] = (state_nxt != state_r);
  assign events[psd_pkg::ST_REFUSED] = refused;
  assign events[psd_pkg::ST_SENT] = repSent;

  // ************************************************************
  // Read data
  // ************************************************************
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dpValid_r && !dpWrite_r) begin
      case (dpAddr_r)
        psd_pkg::ADDR_CTRL: hrdata = {30'h0000_0000, eng_r, run_r};
        psd_pkg::ADDR_STATUS: hrdata = {29'h0000_0000, status_r};
        psd_pkg::ADDR_MASK: hrdata = {29'h0000_0000, mask_r};
        psd_pkg::ADDR_RESULT: hrdata = {20'h00000, 3'h0, staHit_r, 3'h0, motHit_r, 1'b0, occupied, state_r};
        psd_pkg::ADDR_LIMITS: hrdata = run_r ? 32'h0000_0000 :
          {20'h00000, cfg_r.staLimit, 4'h0, cfg_r.motLimit};
        psd_pkg::ADDR_HOLD: hrdata = run_r ? 32'h0000_0000 : {16'h0000, cfg_r.holdSecs};
        default: begin
          if (dpAddr_r[7:5] == psd_pkg::PAGE_THR && !run_r) begin
            hrdata = {17'h00000, cfg_r.staThr[dpAddr_r[4:2]], 1'b0, cfg_r.motThr[dpAddr_r[4:2]]};
          end else if (dpAddr_r[7:5] == psd_pkg::PAGE_ENERGY) begin
            hrdata = {17'h00000, energy_r[dpAddr_r[4:2]].still, 1'b0, energy_r[dpAddr_r[4:2]].motion};
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_limit_excludes;
    @(posedge clock) disable iff (!rst_n)
      frameValid && cfg_r.motLimit == 4'h1 && gateEnergy[0].motion <= cfg_r.motThr[0] |=> !motHit_r;
  endproperty
  a_limit_excludes: assert property (p_limit_excludes) else $error("Gate beyond limit counted.");

  property p_gate_hit;
    @(posedge clock) disable iff (!rst_n)
      frameValid && cfg_r.motLimit != 4'h0 && gateEnergy[0].motion > cfg_r.motThr[0] |=> motHit_r;
  endproperty
  a_gate_hit: assert property (p_gate_hit) else $error("Qualifying energy missed.");

  property p_thr_full_blocks;
    @(posedge clock) disable iff (!rst_n)
      frameValid && cfg_r.staLimit == 4'h1 && cfg_r.staThr[0] == psd_pkg::ENERGY_MAX
      && gateEnergy[0].still <= psd_pkg::ENERGY_MAX |=> !staHit_r;
  endproperty
  a_thr_full_blocks: assert property (p_thr_full_blocks) else $error("Disabled gate detected.");

  property p_motion_wins;
    @(posedge clock) disable iff (!rst_n) motHit_r && occupied |=> state_r == psd_pkg::PSD_MOVING;
  endproperty
  a_motion_wins: assert property (p_motion_wins) else $error("Motion not reported.");

  property p_state_legal;
    @(posedge clock) disable iff (!rst_n) state_r != 2'b11 && (state_r == psd_pkg::PSD_NONE) == !$past(occupied);
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("Illegal target state.");

  property p_locked_cfg;
    @(posedge clock) disable iff (!rst_n) refused && !nvmCfgValid |=> $stable(cfg_r) && status_r[psd_pkg::ST_REFUSED];
  endproperty
  a_locked_cfg: assert property (p_locked_cfg) else $error("Settings changed while running.");

  property p_save_strobe;
    @(posedge clock) disable iff (!rst_n)
      dpValid_r && dpWrite_r && dpAddr_r == psd_pkg::ADDR_CTRL && hwdata[psd_pkg::CTRL_SAVE] && !run_r
      |=> nvmSaveStb ##1 !nvmSaveStb;
  endproperty
  a_save_strobe: assert property (p_save_strobe) else $error("Save strobe missing.");

  property p_energy_latched;
    @(posedge clock) disable iff (!rst_n) frameValid |=> energy_r == $past(gateEnergy);
  endproperty
  a_energy_latched: assert property (p_energy_latched) else $error("Energies not captured.");
endmodule
`default_nettype wire

// ===== test/psd_host_model.sv
// Host side serial receiver that decodes report bytes sent by the block.
`timescale 1ns/1ps
`default_nettype none
module psd_host_model #(
  parameter int DIV = psd_pkg::BAUD_DIV
) (
  input wire logic clock,
  input wire logic rxd,
  output logic [7:0] rxCount,
  output logic [15:0] rxLog,
  output logic stopErr
);
  logic [7:0] shiftIn;
  // ****************************************
  // Byte receiver
  // ****************************************
  initial begin
    rxCount = 8'h00;
    rxLog = 16'h0000;
    stopErr = 1'b0;
    forever begin
      @(negedge rxd);
      repeat (DIV / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clock);
        shiftIn[i] = rxd;
      end
      repeat (DIV) @(posedge clock);
      if (rxd !== 1'b1) begin
        stopErr = 1'b1;
      end
      rxLog = {rxLog[7:0], shiftIn};
      rxCount = rxCount + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the presence gate decision block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_n, hsel, hwrite, frameValid, nvmCfgValid, hreadyout, hresp, nvmSaveStb, txd, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  psd_pkg::psd_energy_t [psd_pkg::NUM_GATES-1:0] gateEnergy;
  psd_pkg::psd_cfg_t nvmCfgIn, nvmCfgOut, cfg;
  psd_pkg::psd_state_t targetState;
  logic [7:0] rxCount;
  logic [15:0] rxLog;
  logic stopErr;
  int bad_count = 0, total_checks = 0, cycles = 0, saves = 0;

  psd_gate_decision #(.TICKS_PER_SEC(20)) u_psd_gate_decision (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frameValid(frameValid), .gateEnergy(gateEnergy),
    .nvmCfgValid(nvmCfgValid), .nvmCfgIn(nvmCfgIn), .nvmSaveStb(nvmSaveStb),
    .nvmCfgOut(nvmCfgOut), .txd(txd), .targetState(targetState), .irq(irq));
  psd_host_model u_psd_host_model (.clock(clock), .rxd(txd), .rxCount(rxCount),
    .rxLog(rxLog), .stopErr(stopErr));

  initial begin
    forever #4 clock = ~clock;
  end

  // ****************************************
  // Bus, frame and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic st(input psd_pkg::psd_state_t exp);
    bus(1'b0, psd_pkg::ADDR_RESULT, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, exp});
    chk({30'h0, targetState}, {30'h0, exp});
  endtask
  task automatic frame(input int g, input logic [6:0] m, input logic [6:0] s);
    psd_pkg::psd_energy_t [psd_pkg::NUM_GATES-1:0] e;
    e = '0;
    e[g] = {m, s};
    gateEnergy <= e;
    frameValid <= 1'b1;
    @(posedge clock);
    frameValid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic done(input string name);
    $display("Test %s finished, mismatches so far %0d", name, bad_count);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (nvmSaveStb === 1'b1) begin
      saves++;
    end
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    frameValid = 1'b0;
    gateEnergy = '0;
    nvmCfgValid = 1'b0;
    nvmCfgIn = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdchk(psd_pkg::ADDR_LIMITS, 32'h00000808);
    rdchk(psd_pkg::ADDR_HOLD, 32'h00000005);
    rdchk(8'h20, 32'h00000032);
    rdchk(8'h3C, 32'h0000140F);
    done("reset");
    bus(1'b1, psd_pkg::ADDR_LIMITS, 32'h00000101);
    bus(1'b1, psd_pkg::ADDR_LIMITS, 32'h00000909);
    rdchk(psd_pkg::ADDR_LIMITS, 32'h00000101);
    bus(1'b1, psd_pkg::ADDR_HOLD, 32'h0000FFFF);
    rdchk(psd_pkg::ADDR_HOLD, 32'h0000FFFF);
    bus(1'b1, psd_pkg::ADDR_HOLD, 32'h00000000);
    bus(1'b1, 8'h20, 32'h00001E32);
    frame(0, 7'h32, 7'h1E);
    st(psd_pkg::PSD_NONE);
    frame(0, 7'h33, 7'h00);
    st(psd_pkg::PSD_MOVING);
    frame(0, 7'h00, 7'h1F);
    st(psd_pkg::PSD_STATIC);
    frame(0, 7'h33, 7'h1F);
    st(psd_pkg::PSD_MOVING);
    frame(1, 7'h64, 7'h64);
    st(psd_pkg::PSD_NONE);
    bus(1'b1, 8'h20, 32'h00007F7F);
    rdchk(8'h20, 32'h00006464);
    frame(0, 7'h64, 7'h64);
    st(psd_pkg::PSD_NONE);
    rdchk(8'h40, 32'h00006464);
    done("decision");
    bus(1'b1, 8'h20, 32'h00001E32);
    bus(1'b1, psd_pkg::ADDR_HOLD, 32'h00000002);
    frame(0, 7'h33, 7'h00);
    frame(0, 7'h00, 7'h00);
    repeat (25) @(posedge clock);
    frame(0, 7'h33, 7'h00);
    frame(0, 7'h00, 7'h00);
    repeat (20) @(posedge clock);
    st(psd_pkg::PSD_MOVING);
    repeat (50) @(posedge clock);
    st(psd_pkg::PSD_NONE);
    done("hold");
    bus(1'b1, psd_pkg::ADDR_MASK, 32'h00000002);
    bus(1'b1, psd_pkg::ADDR_CTRL, 32'h00000001);
    frame(0, 7'h33, 7'h00);
    for (int i = 0; i < 12000 && rxCount < 8'h02; i++) @(posedge clock);
    chk({24'h0, rxCount}, 32'h00000002);
    chk({24'h0, rxLog[15:8]}, {24'h0, psd_pkg::REPORT_HDR});
    chk({24'h0, rxLog[7:0]}, 32'h00000001);
    chk({31'h0, stopErr}, 32'h0);
    bus(1'b1, psd_pkg::ADDR_HOLD, 32'h00000007);
    rdchk(psd_pkg::ADDR_HOLD, 32'h00000000);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, psd_pkg::ADDR_STATUS, 32'h0);
    chk({30'h0, rd[2:1]}, 32'h00000003);
    chk({31'h0, irq}, 32'h00000001);
    bus(1'b1, psd_pkg::ADDR_CTRL, 32'h00000000);
    rdchk(psd_pkg::ADDR_HOLD, 32'h00000002);
    bus(1'b1, psd_pkg::ADDR_STATUS, 32'h00000007);
    rdchk(psd_pkg::ADDR_STATUS, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
    rdchk(8'hFC, 32'h00000000);
    done("report");
    bus(1'b1, psd_pkg::ADDR_CTRL, 32'h00000003);
    frame(0, 7'h33, 7'h00);
    for (int i = 0; i < 16000 && rxCount < 8'h05; i++) @(posedge clock);
    chk({24'h0, rxCount}, 32'h00000005);
    chk({16'h0, rxLog}, 32'h00000133);
    chk({31'h0, stopErr}, 32'h0);
    bus(1'b1, psd_pkg::ADDR_CTRL, 32'h00000000);
    done("engineering");
    bus(1'b1, psd_pkg::ADDR_CTRL, 32'h00000004);
    repeat (2) @(posedge clock);
    chk(saves, 32'h00000001);
    chk({16'h0, nvmCfgOut.holdSecs}, 32'h00000002);
    cfg = nvmCfgOut;
    cfg.holdSecs = 16'h0009;
    nvmCfgIn <= cfg;
    nvmCfgValid <= 1'b1;
    @(posedge clock);
    nvmCfgValid <= 1'b0;
    @(posedge clock);
    rdchk(psd_pkg::ADDR_HOLD, 32'h00000009);
    done("storage");
    results();
  end
endmodule
`default_nettype wire
